// [rtl/diag_flag_bank.v]
// Sticky diagnostic and wake-source flag bank, cleared by host reads
// Functional notes
// - Forced wake sets flag; read clears
// - Interrupt service timeout sets flag; read clears
// - Record supply-off low-power mode; read clears
// - SPI reset request sets flag; read clears
// - Debug exit on low pin sets flag
// - SPI interrupt request sets flag; read clears
// - Reset pin stuck high sets flag
// - Debug resistor mismatch; clears when matched, read
// - Regulator prewarning; clears when cool and read
// - Supply under threshold over 100us flagged
// - Two overvoltage flags; optional I/O-1 switch-off
// - Supply under threshold over 100ms flagged
// - Supply-low flag; clears when supply recovers and read
// - Reset pin low over 100ms flagged
// - More than 8 watchdog resets flagged
// - Watchdog refresh failure sets flag
// - LIN wake on either channel flagged
// - LIN termination short to ground flagged
// - LIN overtemperature; clears when cool and read
// - Receive stuck low, stuck recessive, flagged
// - Transmit input stuck dominant flagged
// - Bus dominant past timeout flagged
// - Summary bits 15,14,13 show pending flags
`timescale 1ns/10ps
`include "flag_bank_defs.vh"

module diag_flag_bank #(
	parameter UV_SHORT_CYC = `UV_SHORT_CYC,
	parameter OV_CYC       = `OV_CYC,
	parameter UV_LONG_CYC  = `UV_LONG_CYC,
	parameter RST_LOW_CYC  = `RST_LOW_CYC,
	parameter CNT_W        = 23
) (
	// Clock and reset
	input  wire                    ref_clk,
	input  wire                    sys_rst,
	// Event pulses from same-clock logic
	input  wire                    forced_wake_evt,
	input  wire                    int_timeout_evt,
	input  wire                    lp_vdd_off_sel_evt,
	input  wire                    spi_rst_req_evt,
	input  wire                    dbg_exit_evt,
	input  wire                    spi_int_req_evt,
	input  wire                    wd_fail_evt,
	input  wire                    wd_reset_evt,
	input  wire                    wd_good_refresh,
	input  wire                    lin_wake_evt,
	// Analog comparator levels, asynchronous
	input  wire                    rst_pin_high_short,
	input  wire                    debug_config_pin_mismatch,
	input  wire                    vdd_temp_above,
	input  wire                    vdd_below_uv,
	input  wire                    vdd_above_ov,
	input  wire                    vaux_above_ov,
	input  wire                    rst_pin_low,
	input  wire                    lin_term_short,
	input  wire                    lin_over_temp,
	input  wire                    lin_receive_out_low,
	input  wire                    lin_receive_out_high,
	input  wire                    lin_transmit_in_dom,
	input  wire                    lin_bus_dominant_timeout,
	// Configuration
	input  wire                    ov_io1_off_en,
	// Host read port
	input  wire                    rd_strobe,
	input  wire [`NUM_FLAGS-1:0]   rd_mask,
	// Outputs
	output reg  [`NUM_FLAGS-1:0]   rd_data_ff,
	output wire [`NUM_FLAGS-1:0]   flags,
	output wire [15:0]             summary,
	output reg                     io1_off_ff
);

	localparam NA = 13;

	// Three-stage sync; second and third must agree
	reg  [NA-1:0] s1_ff;
	reg  [NA-1:0] s2_ff;
	reg  [NA-1:0] s3_ff;
	reg  [NA-1:0] lvl_ff;
	wire [NA-1:0] raw_in;
	wire [NA-1:0] nxt_lvl;

	// Order sets the lvl_ff index of each input
	assign raw_in = {
		// LIN transceiver faults
		lin_bus_dominant_timeout,
		lin_transmit_in_dom,
		lin_receive_out_high,
		lin_receive_out_low,
		lin_over_temp,
		lin_term_short,
		// Supervisor and supply monitors
		rst_pin_low,
		vaux_above_ov,
		vdd_above_ov,
		vdd_below_uv,
		vdd_temp_above,
		debug_config_pin_mismatch,
		rst_pin_high_short
	};
	assign nxt_lvl = (s2_ff == s3_ff) ? s3_ff : lvl_ff;

	always @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			s1_ff <= {NA{1'b0}};
			s2_ff <= {NA{1'b0}};
			s3_ff <= {NA{1'b0}};
		end
		else
		begin
			s1_ff <= raw_in;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end

	// A level moves only when the last two stages agree
	always @(posedge ref_clk)
	begin
		if (sys_rst)
			lvl_ff <= {NA{1'b0}};
		else
			lvl_ff <= nxt_lvl;
	end

	wire rst_high_l = lvl_ff[0];
	wire dbg_mis_l  = lvl_ff[1];
	wire temp_l     = lvl_ff[2];
	wire uv_l       = lvl_ff[3];
	wire ov_l       = lvl_ff[4];
	wire aux_ov_l   = lvl_ff[5];
	wire rst_low_l  = lvl_ff[6];
	wire term_l     = lvl_ff[7];
	wire lin_ot_l   = lvl_ff[8];
	wire rx_low_l   = lvl_ff[9];
	wire rx_high_l  = lvl_ff[10];
	wire tx_dom_l   = lvl_ff[11];
	wire lin_dom_l  = lvl_ff[12];

	// Duration counters; saturate so a held fault keeps its flag up
	reg  [CNT_W-1:0] uv_cnt_ff;
	reg  [CNT_W-1:0] ov_cnt_ff;
	reg  [CNT_W-1:0] aux_cnt_ff;
	reg  [CNT_W-1:0] rl_cnt_ff;
	reg  [3:0]       wd_cnt_ff;
	wire             uv_short_hit;
	wire             uv_long_hit;
	wire             ov_hit;
	wire             aux_hit;
	wire             rl_hit;
	wire             multi_hit;
	wire [3:0]       wd_limit;

	// Counters stop at their limit, so compares never wrap
	assign uv_short_hit = (uv_cnt_ff >= UV_SHORT_CYC[CNT_W-1:0]);
	assign uv_long_hit  = (uv_cnt_ff >= UV_LONG_CYC[CNT_W-1:0]);
	assign ov_hit       = (ov_cnt_ff >= OV_CYC[CNT_W-1:0]);
	assign aux_hit      = (aux_cnt_ff >= OV_CYC[CNT_W-1:0]);
	assign rl_hit       = (rl_cnt_ff >= RST_LOW_CYC[CNT_W-1:0]);
	assign wd_limit     = `MULTI_RST_LIMIT;

	assign multi_hit = wd_reset_evt && (wd_cnt_ff >= wd_limit);

	// Undervoltage time, shared by the short and long flags
	always @(posedge ref_clk)
	begin
		if (sys_rst)
			uv_cnt_ff <= {CNT_W{1'b0}};
		else if (!uv_l)
			uv_cnt_ff <= {CNT_W{1'b0}};
		else if (!uv_long_hit)
			uv_cnt_ff <= uv_cnt_ff + 1'b1;
	end

	// Supply overvoltage time
	always @(posedge ref_clk)
	begin
		if (sys_rst)
			ov_cnt_ff <= {CNT_W{1'b0}};
		else if (!ov_l)
			ov_cnt_ff <= {CNT_W{1'b0}};
		else if (!ov_hit)
			ov_cnt_ff <= ov_cnt_ff + 1'b1;
	end

	// Auxiliary overvoltage time
	always @(posedge ref_clk)
	begin
		if (sys_rst)
			aux_cnt_ff <= {CNT_W{1'b0}};
		else if (!aux_ov_l)
			aux_cnt_ff <= {CNT_W{1'b0}};
		else if (!aux_hit)
			aux_cnt_ff <= aux_cnt_ff + 1'b1;
	end

	// Reset pin low time
	always @(posedge ref_clk)
	begin
		if (sys_rst)
			rl_cnt_ff <= {CNT_W{1'b0}};
		else if (!rst_low_l)
			rl_cnt_ff <= {CNT_W{1'b0}};
		else if (!rl_hit)
			rl_cnt_ff <= rl_cnt_ff + 1'b1;
	end

	// Consecutive watchdog resets; a good refresh restarts the run
	always @(posedge ref_clk)
	begin
		if (sys_rst)
			wd_cnt_ff <= 4'h0;
		else if (wd_good_refresh)
			wd_cnt_ff <= 4'h0;
		else if (wd_reset_evt && (wd_cnt_ff != 4'hF))
			wd_cnt_ff <= wd_cnt_ff + 4'h1;
	end

	// Set terms, and which flags need the condition gone to clear
	reg [`NUM_FLAGS-1:0] set_v;
	reg [`NUM_FLAGS-1:0] hold_v;

	always @*
	begin
		set_v = {`NUM_FLAGS{1'b0}};
		set_v[`F_FORCED_WAKE]  = forced_wake_evt;
		set_v[`F_INT_TIMEOUT]  = int_timeout_evt;
		set_v[`F_LP_VDD_OFF]   = lp_vdd_off_sel_evt;
		set_v[`F_RST_REQ]      = spi_rst_req_evt;
		set_v[`F_DBG_EXIT]     = dbg_exit_evt;
		set_v[`F_INT_REQ]      = spi_int_req_evt;
		set_v[`F_RST_HIGH]     = rst_high_l;
		set_v[`F_DBG_RES]      = dbg_mis_l;
		set_v[`F_TEMP_PREWARN] = temp_l;
		set_v[`F_MCU_UV]       = uv_l && uv_short_hit;
		set_v[`F_MCU_OV]       = ov_l && ov_hit;
		set_v[`F_AUX_OV]       = aux_ov_l && aux_hit;
		set_v[`F_UV_LONG]      = uv_l && uv_long_hit;
		set_v[`F_SUPPLY_LOW]   = uv_l;
		set_v[`F_RST_LOW]      = rst_low_l && rl_hit;
		set_v[`F_MULTI_RST]    = multi_hit;
		set_v[`F_WD_FAIL]      = wd_fail_evt;
		set_v[`F_LIN_WAKE]     = lin_wake_evt;
		set_v[`F_LIN_TERM]     = term_l;
		set_v[`F_LIN_OT]       = lin_ot_l;
		set_v[`F_RX_LOW]       = rx_low_l;
		set_v[`F_RX_HIGH]      = rx_high_l;
		set_v[`F_TX_DOM]       = tx_dom_l;
		set_v[`F_LIN_DOM]      = lin_dom_l;
	end

	always @*
	begin
		hold_v = {`NUM_FLAGS{1'b0}};
		// Fault flags: clear blocked while the condition is still seen
		hold_v[`F_DBG_RES]      = dbg_mis_l;
		hold_v[`F_TEMP_PREWARN] = temp_l;
		hold_v[`F_MCU_UV]       = uv_l;
		hold_v[`F_MCU_OV]       = ov_l;
		hold_v[`F_AUX_OV]       = aux_ov_l;
		hold_v[`F_UV_LONG]      = uv_l;
		hold_v[`F_RST_LOW]      = rst_low_l;
		hold_v[`F_LIN_TERM]     = term_l;
		hold_v[`F_LIN_OT]       = lin_ot_l;
		hold_v[`F_RX_LOW]       = rx_low_l;
		hold_v[`F_RX_HIGH]      = rx_high_l;
		hold_v[`F_TX_DOM]       = tx_dom_l;
		hold_v[`F_LIN_DOM]      = lin_dom_l;
	end

	reg  [`NUM_FLAGS-1:0] flag_ff;
	reg  [`NUM_FLAGS-1:0] clr_v;
	wire [`NUM_FLAGS-1:0] nxt_flag;
	reg  [`NUM_FLAGS-1:0] nxt_rd_data;
	reg                   nxt_io1_off;

	// Masked flags whose cause has gone are cleared by a read
	always @*
	begin
		clr_v = {`NUM_FLAGS{1'b0}};
		if (rd_strobe)
			clr_v = rd_mask & ~hold_v;
	end

	// Set wins over a clear in the same cycle
	assign nxt_flag = (flag_ff & ~clr_v) | set_v;

	// Read data keeps the last capture between reads
	always @*
	begin
		nxt_rd_data = rd_data_ff;
		nxt_io1_off = 1'b0;
		if (rd_strobe)
			nxt_rd_data = flag_ff & rd_mask;
		if (ov_io1_off_en)
			nxt_io1_off = flag_ff[`F_MCU_OV] ||
				flag_ff[`F_AUX_OV];
	end

	always @(posedge ref_clk)
	begin
		if (sys_rst)
			flag_ff <= {`NUM_FLAGS{1'b0}};
		else
			flag_ff <= nxt_flag;
	end

	always @(posedge ref_clk)
	begin
		if (sys_rst)
			rd_data_ff <= {`NUM_FLAGS{1'b0}};
		else
			rd_data_ff <= nxt_rd_data;
	end

	// Switch-off follows the flags while enabled, so it drops once they clear or ov_io1_off_en goes low
	always @(posedge ref_clk)
	begin
		if (sys_rst)
			io1_off_ff <= 1'b0;
		else
			io1_off_ff <= nxt_io1_off;
	end

	assign flags = flag_ff;

	// Pending indications for the fixed status word
	wire sum_int;
	wire sum_wu;
	wire sum_rst;

	assign sum_int = |(flag_ff & `SUM_MASK_INT);
	assign sum_wu  = |(flag_ff & `SUM_MASK_WU);
	assign sum_rst = |(flag_ff & `SUM_MASK_RST);
	assign summary[`SUM_INT_BIT] = sum_int;
	assign summary[`SUM_WU_BIT]  = sum_wu;
	assign summary[`SUM_RST_BIT] = sum_rst;
	assign summary[12:0] = 13'h0000;

endmodule

// [rtl/flag_bank_defs.vh]
// Constants for the diagnostic flag bank
`ifndef FLAG_BANK_DEFS_VH
`define FLAG_BANK_DEFS_VH
`define CLK_FREQ_HZ      50000000
`define UV_SHORT_TIME_US 100
`define OV_TIME_US       100
`define UV_LONG_TIME_MS  100
`define RST_LOW_TIME_MS  100
`define UV_SHORT_CYC     ((`CLK_FREQ_HZ / 1000000) * `UV_SHORT_TIME_US)
`define OV_CYC           ((`CLK_FREQ_HZ / 1000000) * `OV_TIME_US)
`define UV_LONG_CYC      ((`CLK_FREQ_HZ / 1000) * `UV_LONG_TIME_MS)
`define RST_LOW_CYC      ((`CLK_FREQ_HZ / 1000) * `RST_LOW_TIME_MS)
`define MULTI_RST_LIMIT  4'h8
`define NUM_FLAGS        24
`define F_FORCED_WAKE    0
`define F_INT_TIMEOUT    1
`define F_LP_VDD_OFF     2
`define F_RST_REQ        3
`define F_DBG_EXIT       4
`define F_INT_REQ        5
`define F_RST_HIGH       6
`define F_DBG_RES        7
`define F_TEMP_PREWARN   8
`define F_MCU_UV         9
`define F_MCU_OV         10
`define F_AUX_OV         11
`define F_UV_LONG        12
`define F_SUPPLY_LOW     13
`define F_RST_LOW        14
`define F_MULTI_RST      15
`define F_WD_FAIL        16
`define F_LIN_WAKE       17
`define F_LIN_TERM       18
`define F_LIN_OT         19
`define F_RX_LOW         20
`define F_RX_HIGH        21
`define F_TX_DOM         22
`define F_LIN_DOM        23
`define SUM_INT_BIT      15
`define SUM_WU_BIT       14
`define SUM_RST_BIT      13
`define SUM_MASK_INT     24'h010022
`define SUM_MASK_WU      24'h020005
`define SUM_MASK_RST     24'h01C048
`endif

// [verification/diag_flag_bank_chk.sv]
// Port checks for the flag bank
`timescale 1ns/10ps
`include "flag_bank_defs.vh"
module diag_flag_bank_chk (
	// Clock and reset
	input wire                  ref_clk,
	input wire                  sys_rst,
	// Stimulus seen
	input wire                  forced_wake_evt,
	input wire                  ov_io1_off_en,
	input wire                  rd_strobe,
	input wire [`NUM_FLAGS-1:0] rd_mask,
	// Results seen
	input wire [`NUM_FLAGS-1:0] rd_data_ff,
	input wire [`NUM_FLAGS-1:0] flags,
	input wire [15:0]           summary,
	input wire                  io1_off_ff
);
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst);
	chk_read_capture: assert property (
		rd_strobe |=> rd_data_ff == ($past(flags) & $past(rd_mask)))
		else $error("read data not the flags at the read");
	chk_data_hold: assert property (
		!rd_strobe |=> $stable(rd_data_ff))
		else $error("read data moved without a read");
	chk_sticky_hold: assert property (
		!rd_strobe |=> (flags & $past(flags)) == $past(flags))
		else $error("flag dropped without a read");
	chk_wake_set: assert property (
		forced_wake_evt |=> flags[`F_FORCED_WAKE])
		else $error("forced wake flag not set");
	chk_wake_clear: assert property (
		rd_strobe && rd_mask[`F_FORCED_WAKE] && !forced_wake_evt
		|=> !flags[`F_FORCED_WAKE])
		else $error("forced wake flag not cleared");
	chk_sum_int: assert property (
		summary[`SUM_INT_BIT] == |(flags & `SUM_MASK_INT))
		else $error("interrupt summary wrong");
	chk_sum_wake: assert property (
		summary[`SUM_WU_BIT] == |(flags & `SUM_MASK_WU))
		else $error("wake summary wrong");
	chk_sum_rst: assert property (
		summary[12:0] == 13'h0000 &&
		summary[`SUM_RST_BIT] == |(flags & `SUM_MASK_RST))
		else $error("reset summary wrong");
	chk_io1_off: assert property (
		(ov_io1_off_en && (flags[`F_MCU_OV] || flags[`F_AUX_OV])) [*2]
		|-> io1_off_ff)
		else $error("io1 not switched off");
endmodule
bind diag_flag_bank diag_flag_bank_chk u_chk (.ref_clk, .sys_rst,
	.forced_wake_evt, .ov_io1_off_en, .rd_strobe, .rd_mask,
	.rd_data_ff, .flags, .summary, .io1_off_ff);

// [verification/diag_flag_bank_tb_top.sv]
// Random and corner tests of the flag bank
`timescale 1ns/10ps
`include "flag_bank_defs.vh"
module diag_flag_bank_tb_top;
	reg          ref_clk;
	reg          sys_rst;
	reg  [7:0]   evt;
	reg          wd_rst;
	reg          wd_ok;
	reg  [12:0]  lvl;
	reg          cfg_en;
	reg          go;
	reg  [23:0]  mask_in;
	wire         rd_strobe;
	wire [23:0]  rd_mask;
	wire [23:0]  rd_data_ff;
	wire [23:0]  flags;
	wire [15:0]  summary;
	wire         io1_off_ff;
	int          mismatches;
	int          n_compared;
	int          i;
	int          k;
	logic [7:0]  rv;
	logic [23:0] e;
	logic [23:0] m;
	host_reader host (.ref_clk(ref_clk), .go(go), .mask_in(mask_in),
		.rd_strobe(rd_strobe), .rd_mask(rd_mask));
	// Short timed counts keep the run brief
	diag_flag_bank #(.UV_SHORT_CYC(5), .OV_CYC(5), .UV_LONG_CYC(20),
		.RST_LOW_CYC(40)) DUT (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.forced_wake_evt(evt[0]), .int_timeout_evt(evt[1]),
		.lp_vdd_off_sel_evt(evt[2]), .spi_rst_req_evt(evt[3]),
		.dbg_exit_evt(evt[4]), .spi_int_req_evt(evt[5]),
		.wd_fail_evt(evt[6]), .lin_wake_evt(evt[7]),
		.wd_reset_evt(wd_rst), .wd_good_refresh(wd_ok),
		.rst_pin_high_short(lvl[0]), .debug_config_pin_mismatch(lvl[1]),
		.vdd_temp_above(lvl[2]), .vdd_below_uv(lvl[3]),
		.vdd_above_ov(lvl[4]), .vaux_above_ov(lvl[5]), .rst_pin_low(lvl[6]),
		.lin_term_short(lvl[7]), .lin_over_temp(lvl[8]),
		.lin_receive_out_low(lvl[9]), .lin_receive_out_high(lvl[10]),
		.lin_transmit_in_dom(lvl[11]), .lin_bus_dominant_timeout(lvl[12]),
		.ov_io1_off_en(cfg_en), .rd_strobe(rd_strobe), .rd_mask(rd_mask),
		.rd_data_ff(rd_data_ff), .flags(flags), .summary(summary),
		.io1_off_ff(io1_off_ff));
	function automatic logic [23:0] ev_flag(input int j);
		ev_flag = 24'h000001 << (j < 6 ? j : j + 10);
	endfunction
	function automatic logic [23:0] lv_flag(input int j);
		if (j == 3)
			lv_flag = 24'h003200;
		else
			lv_flag = 24'h000001 << (j < 6 ? j + 6 : j == 6 ? 14 : j + 11);
	endfunction
	function automatic logic [23:0] sum_of(input logic [23:0] f);
		sum_of = {8'h00, |(f & `SUM_MASK_INT), |(f & `SUM_MASK_WU),
			|(f & `SUM_MASK_RST), 13'h0000};
	endfunction
	task automatic cmp(input string what, input logic [23:0] exp,
		input logic [23:0] got);
		n_compared++;
		if (got !== exp)
		begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic rd(input logic [23:0] msk);
		@(negedge ref_clk) go <= 1'b1;
		mask_in <= msk;
		@(negedge ref_clk) go <= 1'b0;
		repeat (2) @(negedge ref_clk);
	endtask
	task automatic wd_pulses(input int n);
		repeat (n)
		begin
			@(negedge ref_clk) wd_rst <= 1'b1;
			@(negedge ref_clk) wd_rst <= 1'b0;
		end
	endtask
	task automatic stop_test;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial
	begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	initial
	begin
		repeat (20000) @(posedge ref_clk);
		mismatches++;
		stop_test;
	end
	initial
	begin
		sys_rst = 1'b1;
		{evt, wd_rst, wd_ok, lvl, cfg_en, go, mask_in} = '0;
		k = $urandom(55);
		repeat (3) @(posedge ref_clk);
		@(negedge ref_clk) sys_rst <= 1'b0;
		cmp("reset", 24'h000000, flags | rd_data_ff | {8'h00, summary});
		for (i = 0; i < 8; i++)
		begin
			@(negedge ref_clk) evt[i] <= 1'b1;
			@(negedge ref_clk) evt[i] <= 1'b0;
			cmp("event flag", ev_flag(i), flags);
			cmp("summary", sum_of(ev_flag(i)), {8'h00, summary});
			rd(24'hFFFFFF);
			cmp("event read", ev_flag(i), rd_data_ff);
			cmp("event clear", 24'h000000, flags);
		end
		for (k = 0; k < 20; k++)
		begin
			rv = $urandom;
			m = $urandom;
			e = 24'h000000;
			for (i = 0; i < 8; i++)
				if (rv[i])
					e = e | ev_flag(i);
			@(negedge ref_clk) evt <= rv;
			@(negedge ref_clk) evt <= 8'h00;
			cmp("random summary", sum_of(e), {8'h00, summary});
			rd(m);
			cmp("masked read", e & m, rd_data_ff);
			cmp("unread kept", e & ~m, flags);
			rd(24'hFFFFFF);
		end
		$display("event tests done");
		for (i = 0; i < 13; i++)
		begin
			k = $urandom;
			// Switch-off path always covered once
			if (i == 4)
				k[0] = 1'b1;
			@(negedge ref_clk) lvl[i] <= 1'b1;
			cfg_en <= k[0];
			repeat (60) @(negedge ref_clk);
			cmp("fault flag", lv_flag(i), flags);
			cmp("io1 off", {23'h000000, k[0] && (i == 4 || i == 5)},
				{23'h000000, io1_off_ff});
			rd(24'hFFFFFF);
			cmp("fault read", lv_flag(i), rd_data_ff);
			cmp("fault kept", lv_flag(i), flags);
			@(negedge ref_clk) lvl[i] <= 1'b0;
			repeat (8) @(negedge ref_clk);
			rd(24'hFFFFFF);
			cmp("fault gone", 24'h000000, flags);
		end
		// Dip too short for the timed flag
		@(negedge ref_clk) lvl[3] <= 1'b1;
		repeat (3) @(negedge ref_clk);
		lvl[3] <= 1'b0;
		repeat (8) @(negedge ref_clk);
		cmp("short dip", 24'h002000, flags);
		rd(24'hFFFFFF);
		$display("fault tests done");
		wd_pulses(8);
		@(negedge ref_clk) wd_ok <= 1'b1;
		@(negedge ref_clk) wd_ok <= 1'b0;
		wd_pulses(8);
		cmp("eight resets", 24'h000000, flags);
		wd_pulses(1);
		cmp("ninth reset", 24'h008000, flags);
		rd(24'hFFFFFF);
		cmp("multi read", 24'h008000, rd_data_ff);
		$display("watchdog tests done");
		stop_test;
	end
endmodule

// [verification/host_reader.sv]
// Host side model issuing flag reads
`timescale 1ns/10ps
module host_reader (
	// Clock and request
	input  wire        ref_clk,
	input  wire        go,
	input  wire [23:0] mask_in,
	// Read port
	output reg         rd_strobe = 1'b0,
	output reg  [23:0] rd_mask = 24'h000000
);
	// Idle mask toggles so a stale value is never trusted
	always @(negedge ref_clk)
	begin
		rd_strobe <= go;
		rd_mask   <= go ? mask_in : ~rd_mask;
	end
endmodule
